// file: lane_lock.sv
// Per-lane code-group boundary lock machine
`timescale 1ns/100ps
module lane_lock (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic sync_clear,
  input  wire logic cg_strobe,
  input  wire logic comma,
  input  wire logic invalid,
  input  wire logic energy_ok,
  output logic      locked_q
);

  typedef enum logic [2:0] {UNLOCKED, COUNT1, COUNT2, LOCKED,
                            CHECK1, CHECK2, CHECK3, CHECK4} lock_type;

  lock_type   state_q;
  logic [6:0] comma_cnt_q;
  logic [7:0] valid_cnt_q;
  logic       inval_cnt_q;

  // ----------------------------------------------------------------------
  // State and counters, one code-group per strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= UNLOCKED;
      comma_cnt_q <= '0;
      valid_cnt_q <= '0;
      inval_cnt_q <= 1'b0;
      locked_q    <= 1'b0;
    end else if (sync_clear) begin
      state_q     <= UNLOCKED;
      comma_cnt_q <= '0;
      valid_cnt_q <= '0;
      inval_cnt_q <= 1'b0;
      locked_q    <= 1'b0;
    end else if (cg_strobe) begin
      unique case (state_q)
        UNLOCKED: begin
          comma_cnt_q <= '0;
          locked_q    <= 1'b0;
          if (comma && energy_ok) begin
            state_q <= COUNT1;
          end
        end
        COUNT1, COUNT2: begin
          if (invalid) begin
            state_q <= UNLOCKED;
          end else if (comma && comma_cnt_q == lane_sync_pkg::COMMA_LAST) begin
            state_q     <= LOCKED;
            locked_q    <= 1'b1;
            inval_cnt_q <= 1'b0;
          end else if (comma) begin
            comma_cnt_q <= comma_cnt_q + 1'b1;
            state_q     <= COUNT1;
          end else begin
            state_q <= COUNT2;
          end
        end
        LOCKED: begin
          // A lone error starts a probation run instead of a realign
          if (invalid) begin
            state_q     <= CHECK1;
            inval_cnt_q <= 1'b1;
            valid_cnt_q <= '0;
          end
        end
        default: begin
          // Check phases follow the top bits of the valid run
          if (invalid) begin
            state_q  <= UNLOCKED;
            locked_q <= 1'b0;
          end else if (valid_cnt_q == lane_sync_pkg::VALID_LAST) begin
            state_q     <= LOCKED;
            inval_cnt_q <= 1'b0;
          end else begin
            valid_cnt_q <= valid_cnt_q + 1'b1;
            state_q     <= lock_type'({1'b1, valid_cnt_q[7:6]} +
                                      ((valid_cnt_q[5:0] == 6'h3F) ?
                                       3'h1 : 3'h0));
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_clear_unlocks: assert property (
    @(posedge clk) disable iff (!reset_n)
    sync_clear |=> state_q == UNLOCKED && !locked_q)
    else $error("clear did not unlock lane");

  chk_lock_needs_count: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(locked_q) |-> $past(comma_cnt_q) == lane_sync_pkg::COMMA_LAST)
    else $error("lock without full comma count");

  chk_second_error_drops: assert property (
    @(posedge clk) disable iff (!reset_n)
    (cg_strobe && invalid && state_q >= CHECK1 && !sync_clear)
    |=> !locked_q && state_q == UNLOCKED)
    else $error("second error kept lock");

  chk_single_error_holds: assert property (
    @(posedge clk) disable iff (!reset_n)
    (cg_strobe && invalid && state_q == LOCKED && !sync_clear)
    |=> locked_q && state_q == CHECK1 && inval_cnt_q)
    else $error("single error dropped lock");

  cov_lock_reached: cover property (@(posedge clk) $rose(locked_q));
  cov_probation_pass: cover property (@(posedge clk)
    state_q == CHECK4 ##1 state_q == LOCKED);

endmodule : lane_lock

// file: lane_sync_pkg.sv
// Shared constants, register map and code-group classification
package lane_sync_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ          = 25;
  localparam int SILENCE_US       = 120;
  localparam int SILENCE_TOL_US   = 40;
  localparam int SILENCE_CYCLES   = SILENCE_US * CLK_MHZ;
  localparam int DISCOVERY_MS     = 12;
  localparam int DISCOVERY_TOL_MS = 4;
  localparam int DISCOVERY_CYCLES = DISCOVERY_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W          = 19;

  // ----------------------------------------------------------------------
  // Lock hysteresis
  // ----------------------------------------------------------------------
  localparam logic [6:0] COMMA_LAST = 7'h7E;
  localparam logic [7:0] VALID_LAST = 8'hFE;
  localparam int         LANES      = 4;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int NARROW_BIT  = 0;
  localparam int ALT_BIT     = 1;
  localparam int ENERGY_BIT  = 2;
  localparam int REINIT_BIT  = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int ST_LOCK_LSB = 0;
  localparam int ST_ALIGNED  = 4;
  localparam int ST_LINK_UP  = 5;
  localparam int ST_WIDE     = 6;
  localparam int ST_ALT      = 7;
  localparam int ST_SIL_DONE = 8;
  localparam int ST_DIS_DONE = 9;

  // ----------------------------------------------------------------------
  // Comma code-group, both disparities, bit 9 sent first
  // ----------------------------------------------------------------------
  localparam logic [9:0] COMMA_NEG = 10'h0FA;
  localparam logic [9:0] COMMA_POS = 10'h305;

  // Returns {comma, invalid, next running disparity}; rd 1 means positive
  function automatic logic [2:0] classify(input logic [9:0] cg,
                                          input logic       rd);
    int   ones;
    logic bad;
    logic rd_n;
    ones = 0;
    for (int i = 0; i < 10; i++) begin
      ones = ones + int'(cg[i]);
    end
    bad  = 1'b0;
    rd_n = rd;
    if (ones == 6) begin
      bad  = rd;
      rd_n = 1'b1;
    end else if (ones == 4) begin
      bad  = ~rd;
      rd_n = 1'b0;
    end else if (ones != 5) begin
      bad  = 1'b1;
    end
    if (bad) begin
      rd_n = rd;
    end
    classify = {~bad & (rd ? (cg == COMMA_POS) : (cg == COMMA_NEG)),
                bad, rd_n};
  endfunction : classify

endpackage : lane_sync_pkg

// file: link_partner_model.sv
// Link partner model sending comma idles on four lanes
`timescale 1ns/100ps
module link_partner_model (
  input  wire logic       run,
  output logic      [3:0] cg_clk,
  output logic      [9:0] cg_lane [4]
);
  logic       lclk = 1'b0;
  logic [3:0] rd   = 4'hF;
  logic [3:0] err  = 4'h0;

  assign cg_clk = {4{lclk}};

  // Offset start keeps lane edges 13 ns after a system clock falling edge, off both clock edges
  initial begin
    cg_lane = '{default: 10'h0FA};
    #13;
    forever #160 lclk = run ? ~lclk : 1'b0;
  end

  // Next group carries a weight that is never legal
  task automatic send_error(input int l);
    err[l] = 1'b1;
  endtask : send_error

  // Alternating comma groups keep disparity balanced
  always @(negedge lclk or negedge run) begin
    for (int l = 0; l < 4; l++) begin
      if (!run) begin
        cg_lane[l] <= ~cg_lane[l];
      end else if (err[l]) begin
        cg_lane[l] <= 10'h3FF;
        err[l] = 1'b0;
      end else begin
        cg_lane[l] <= rd[l] ? 10'h305 : 10'h0FA;
        rd[l] <= ~rd[l];
      end
    end
  end
endmodule : link_partner_model

// file: run_timer.sv
// Run-gated expiry timer
`timescale 1ns/100ps
module run_timer #(
  parameter int LIMIT = 16
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic run,
  output logic      done
);

  logic [lane_sync_pkg::TIMER_W-1:0] count_q;

  // Holds at zero while idle, saturates at the limit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (!run) begin
      count_q <= '0;
    end else if (count_q != lane_sync_pkg::TIMER_W'(LIMIT)) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign done = run && (count_q == lane_sync_pkg::TIMER_W'(LIMIT));

  chk_timer_idle_zero: assert property (
    @(posedge clk) disable iff (!reset_n) !run |=> count_q == '0)
    else $error("timer not held at initial value");

endmodule : run_timer

// file: serial_lane_sync_monitor.sv
// Lane lock monitor with port initialization control and APB registers
`timescale 1ns/100ps

// Summary of operation
// - Timers run only while enabled, else reset
// - Silence timer expires after 120 microseconds
// - Narrow force selects single-lane even when aligned
// - Alt-lane force takes lane 2 in single-lane
// - Two enables: lanes 0/2 and lanes 1/3
// - Single-lane port drives only with its enable
// - Aligned only when four lanes locked, aligned
// - Link-up only when initialized; otherwise idles only
// - Alt-selected high for lane 2, low lane 0
// - Alt-selected meaningless in four-lane mode
// - Energy-ok qualifier gates leaving unlocked state
// - One lock machine single, four dual-width
// - Lone bit error never shifts the alignment
// - Unlocked clears comma counter; comma with energy advances
// - 127 more commas without errors reach lock
// - Lock sets flag, clears error counter
// - 255 valid groups restore lock, error unlocks
// - Two errors within 256 groups drop lock
// - Classify each group by running disparity
// - Comma sequence establishes code-group boundary
// - Separate counters kept for every lane
// - Discovery timer expires after 12 milliseconds
// - States persist; assigned values hold until changed
module serial_lane_sync_monitor #(
  parameter bit dual_width       = 1'b1,
  parameter int discovery_cycles = lane_sync_pkg::DISCOVERY_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  rx_cg_clk,
  input  wire logic [9:0]  rx_cg_lane0,
  input  wire logic [9:0]  rx_cg_lane1,
  input  wire logic [9:0]  rx_cg_lane2,
  input  wire logic [9:0]  rx_cg_lane3,
  input  wire logic [3:0]  energy_ok,
  input  wire logic        deskew_aligned,
  output logic [3:0]       lane_locked,
  output logic             lanes_aligned,
  output logic             link_up,
  output logic             idle_only,
  output logic             wide_mode,
  output logic             alt_lane_selected,
  output logic             even_pair_tx_enable,
  output logic             odd_pair_tx_enable,
  output logic             link_tx_enable
);

  typedef enum logic [2:0] {SILENT, SEEK, DISCOVER, WIDE, NARROW0,
                            NARROW2} init_type;

  localparam int NLANES = dual_width ? lane_sync_pkg::LANES : 1;

  // ----------------------------------------------------------------------
  // Lane receive path
  // ----------------------------------------------------------------------
  logic [9:0] lane_cg [lane_sync_pkg::LANES];
  logic [3:0] lock_w;
  logic [3:0] clk_s1_q;
  logic [3:0] clk_s2_q;
  logic [3:0] clk_s3_q;
  logic [3:0] en_s1_q;
  logic [3:0] en_s2_q;
  logic [3:0] strobe_q;
  logic [3:0] comma_q;
  logic [3:0] inval_q;
  logic [3:0] rd_q;
  logic [9:0] cg_s1_q [lane_sync_pkg::LANES];
  logic [9:0] cg_s2_q [lane_sync_pkg::LANES];
  logic       sync_clear;
  logic [2:0] ctrl_q;
  logic       energy_bypass;

  assign lane_cg[0] = rx_cg_lane0;
  assign lane_cg[1] = rx_cg_lane1;
  assign lane_cg[2] = rx_cg_lane2;
  assign lane_cg[3] = rx_cg_lane3;
  assign energy_bypass = ctrl_q[lane_sync_pkg::ENERGY_BIT];

  // Lane clock and data cross by two flops; data settles half a
  // lane period before the synchronised rising edge is seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1_q <= 4'h0;
      clk_s2_q <= 4'h0;
      clk_s3_q <= 4'h0;
      en_s1_q  <= 4'h0;
      en_s2_q  <= 4'h0;
    end else begin
      clk_s1_q <= rx_cg_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      en_s1_q  <= energy_ok;
      en_s2_q  <= en_s1_q;
    end
  end

  for (genvar l = 0; l < lane_sync_pkg::LANES; l++) begin : g_rx
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cg_s1_q[l] <= 10'h000;
        cg_s2_q[l] <= 10'h000;
      end else begin
        cg_s1_q[l] <= lane_cg[l];
        cg_s2_q[l] <= cg_s1_q[l];
      end
    end

    // Classify once per code-group and track disparity per lane
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        strobe_q[l] <= 1'b0;
        comma_q[l]  <= 1'b0;
        inval_q[l]  <= 1'b0;
        rd_q[l]     <= 1'b0;
      end else begin
        strobe_q[l] <= clk_s2_q[l] && !clk_s3_q[l];
        if (clk_s2_q[l] && !clk_s3_q[l]) begin
          {comma_q[l], inval_q[l], rd_q[l]} <=
            lane_sync_pkg::classify(cg_s2_q[l], rd_q[l]);
        end
      end
    end
  end

  for (genvar l = 0; l < lane_sync_pkg::LANES; l++) begin : g_lock
    if (l < NLANES) begin : g_on
      lane_lock u_lock (
        .clk        (clk),
        .reset_n    (reset_n),
        .sync_clear (sync_clear),
        .cg_strobe  (strobe_q[l]),
        .comma      (comma_q[l]),
        .invalid    (inval_q[l]),
        .energy_ok  (en_s2_q[l] | energy_bypass),
        .locked_q   (lock_w[l])
      );
    end else begin : g_off
      assign lock_w[l] = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  init_type state_q;
  logic     silence_done;
  logic     discovery_done;
  logic     reinit_q;
  logic     all_aligned;

  run_timer #(.LIMIT(lane_sync_pkg::SILENCE_CYCLES)) u_silence (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (state_q == SILENT),
    .done    (silence_done)
  );

  run_timer #(.LIMIT(discovery_cycles)) u_discovery (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (state_q == DISCOVER),
    .done    (discovery_done)
  );

  // ----------------------------------------------------------------------
  // Initialization sequence
  // ----------------------------------------------------------------------
  assign all_aligned = deskew_aligned && (&lock_w) && dual_width;
  assign sync_clear  = reinit_q;

  // Each state holds until one of its exits fires
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SILENT;
    end else if (reinit_q) begin
      state_q <= SILENT;
    end else begin
      unique case (state_q)
        SILENT: begin
          if (silence_done) begin
            state_q <= SEEK;
          end
        end
        SEEK: begin
          if (!dual_width && lock_w[0]) begin
            state_q <= NARROW0;
          end else if (dual_width && (lock_w[0] || lock_w[2])) begin
            state_q <= DISCOVER;
          end
        end
        DISCOVER: begin
          if (all_aligned && !ctrl_q[lane_sync_pkg::NARROW_BIT]) begin
            state_q <= WIDE;
          end else if (discovery_done) begin
            if (lock_w[0] && !ctrl_q[lane_sync_pkg::ALT_BIT]) begin
              state_q <= NARROW0;
            end else if (lock_w[2]) begin
              state_q <= NARROW2;
            end else begin
              state_q <= SILENT;
            end
          end
        end
        WIDE: begin
          if (!all_aligned) begin
            state_q <= SILENT;
          end
        end
        NARROW0: begin
          if (!lock_w[0]) begin
            state_q <= SILENT;
          end
        end
        NARROW2: begin
          if (!lock_w[2]) begin
            state_q <= SILENT;
          end
        end
      endcase
    end
  end

  // Outputs are registered copies of the sequence state and the lane lock status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lane_locked         <= 4'h0;
      lanes_aligned       <= 1'b0;
      link_up             <= 1'b0;
      idle_only           <= 1'b1;
      wide_mode           <= 1'b0;
      alt_lane_selected   <= 1'b0;
      even_pair_tx_enable <= 1'b0;
      odd_pair_tx_enable  <= 1'b0;
      link_tx_enable      <= 1'b0;
    end else begin
      lane_locked         <= lock_w;
      lanes_aligned       <= all_aligned;
      link_up             <= state_q inside {WIDE, NARROW0, NARROW2};
      idle_only           <= !(state_q inside {WIDE, NARROW0, NARROW2});
      wide_mode           <= state_q == WIDE;
      // Driven low in four-lane mode; consumers must ignore it there
      alt_lane_selected   <= state_q == NARROW2;
      even_pair_tx_enable <= dual_width && state_q != SILENT;
      odd_pair_tx_enable  <= dual_width &&
                             state_q inside {DISCOVER, WIDE};
      link_tx_enable      <= !dual_width && state_q != SILENT;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------------
  logic [31:0] status_w;
  logic        wr_take;

  assign status_w = {22'h000000, discovery_done, silence_done,
                     alt_lane_selected, wide_mode, link_up,
                     lanes_aligned, lane_locked};
  assign wr_take  = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready &&
                 !(paddr == lane_sync_pkg::CTRL_OFFSET ||
                   paddr == lane_sync_pkg::STATUS_OFFSET);
      if (psel && penable && !pready && !pwrite) begin
        if (paddr == lane_sync_pkg::CTRL_OFFSET) begin
          prdata <= {29'h00000000, ctrl_q};
        end else if (paddr == lane_sync_pkg::STATUS_OFFSET) begin
          prdata <= status_w;
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // Reinit is a write-one pulse; it also clears every lane machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q   <= lane_sync_pkg::CTRL_RESET;
      reinit_q <= 1'b0;
    end else begin
      reinit_q <= 1'b0;
      if (wr_take && paddr == lane_sync_pkg::CTRL_OFFSET) begin
        ctrl_q   <= pwdata[2:0];
        reinit_q <= pwdata[lane_sync_pkg::REINIT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_silence_expiry: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(state_q == SILENT) |-> !silence_done [*8])
    else $error("silence timer expired early");

  chk_aligned_all_locked: assert property (
    @(posedge clk) disable iff (!reset_n)
    lanes_aligned |-> (&$past(lock_w)) && $past(deskew_aligned))
    else $error("aligned without four locked lanes");

  chk_narrow_force_wide: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_q == DISCOVER && ctrl_q[lane_sync_pkg::NARROW_BIT] && !reinit_q)
    |=> state_q != WIDE)
    else $error("wide mode entered while narrow forced");

  chk_alt_lane_map: assert property (
    @(posedge clk) disable iff (!reset_n)
    (link_up && !wide_mode)
    |-> alt_lane_selected == ($past(state_q) == NARROW2))
    else $error("alt lane output mismatched");

  chk_link_up_idle: assert property (
    @(posedge clk) disable iff (!reset_n) link_up != idle_only)
    else $error("idle_only disagrees with link_up");

  chk_tx_pair_order: assert property (
    @(posedge clk) disable iff (!reset_n)
    odd_pair_tx_enable |-> even_pair_tx_enable)
    else $error("odd pair enabled without even pair");

  cov_wide_up: cover property (@(posedge clk) $rose(wide_mode));
  cov_alt_lane: cover property (@(posedge clk) $rose(alt_lane_selected));
  cov_reinit: cover property (@(posedge clk) link_up ##1 reinit_q);

endmodule : serial_lane_sync_monitor

// file: tb_serial_lane_sync_monitor.sv
// Self-checking bench for the lane lock monitor
`timescale 1ns/100ps
module tb_serial_lane_sync_monitor;
  logic        clk = 1'b0, reset_n, run;
  logic        psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, errv, deskew_aligned;
  logic [3:0]  energy_ok, cg_clk, lane_locked, lock_one;
  logic        tx_dual, tx_one;
  logic [9:0]  cg_lane [4];
  logic        lanes_aligned, link_up, idle_only, wide_mode;
  logic        alt_lane_selected, even_pair_tx_enable, odd_pair_tx_enable;
  int          bad_count = 0, num_checks = 0, cycles = 0;

  always #20 clk = ~clk;

  serial_lane_sync_monitor #(.dual_width(1'b1), .discovery_cycles(200))
    serial_lane_sync_monitor_i (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_cg_clk(cg_clk), .rx_cg_lane0(cg_lane[0]), .rx_cg_lane1(cg_lane[1]),
    .rx_cg_lane2(cg_lane[2]), .rx_cg_lane3(cg_lane[3]),
    .energy_ok(energy_ok), .deskew_aligned(deskew_aligned),
    .lane_locked(lane_locked), .lanes_aligned(lanes_aligned),
    .link_up(link_up), .idle_only(idle_only), .wide_mode(wide_mode),
    .alt_lane_selected(alt_lane_selected),
    .even_pair_tx_enable(even_pair_tx_enable),
    .odd_pair_tx_enable(odd_pair_tx_enable), .link_tx_enable(tx_dual));

  // Single-lane build shares the bus and the lanes
  serial_lane_sync_monitor #(.dual_width(1'b0), .discovery_cycles(200))
    serial_lane_sync_monitor_one_i (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .rx_cg_clk(cg_clk), .rx_cg_lane0(cg_lane[0]), .rx_cg_lane1(cg_lane[1]),
    .rx_cg_lane2(cg_lane[2]), .rx_cg_lane3(cg_lane[3]),
    .energy_ok(energy_ok), .deskew_aligned(deskew_aligned),
    .lane_locked(lock_one), .lanes_aligned(), .link_up(), .idle_only(),
    .wide_mode(), .alt_lane_selected(), .even_pair_tx_enable(),
    .odd_pair_tx_enable(), .link_tx_enable(tx_one));

  link_partner_model link_partner_model_i (.run(run), .cg_clk(cg_clk),
    .cg_lane(cg_lane));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, lane_sync_pkg::STATUS_OFFSET, 32'h0);
    chk(rdv & mask, exp);
  endtask : st

  // Each lane group lasts eight system clocks
  task automatic groups(input int n);
    repeat (n * 8) @(posedge clk);
  endtask : groups

  task automatic wait_up();
    int n;
    n = 0;
    while (link_up !== 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (link_up !== 1'b1) begin
      bad_count++;
    end
  endtask : wait_up

  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    reset_n        <= 1'b0;
    run            <= 1'b0;
    psel           <= 1'b0;
    penable        <= 1'b0;
    pwrite         <= 1'b0;
    paddr          <= 12'h000;
    pwdata         <= 32'h00000000;
    deskew_aligned <= 1'b0;
    energy_ok      <= 4'h7;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    st(32'h0FF, 32'h0);
    chk({idle_only, link_up}, 32'h2);
    chk({30'h0, tx_one, tx_dual}, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    apb(1'b1, lane_sync_pkg::STATUS_OFFSET, 32'hFFFFFFFF);
    chk({31'h0, errv}, 32'h0);
    apb(1'b0, lane_sync_pkg::CTRL_OFFSET, 32'h0);
    chk({31'h0, errv}, 32'h0);
    chk(rdv, 32'h0);
    run <= 1'b1;
    groups(100);
    chk(lane_locked, 32'h0);
    groups(35);
    chk(lane_locked, 32'h7);
    energy_ok <= 4'hF;
    groups(135);
    chk(lane_locked, 32'hF);
    chk({28'h0, lock_one}, 32'h1);
    wait_up();
    chk({wide_mode, alt_lane_selected, even_pair_tx_enable,
         odd_pair_tx_enable, idle_only}, 32'h04);
    link_partner_model_i.send_error(1);
    groups(50);
    chk(lane_locked, 32'hF);
    link_partner_model_i.send_error(1);
    groups(5);
    chk(lane_locked, 32'hD);
    link_partner_model_i.send_error(2);
    groups(260);
    link_partner_model_i.send_error(2);
    groups(5);
    chk(lane_locked, 32'hF);
    deskew_aligned <= 1'b1;
    apb(1'b1, lane_sync_pkg::CTRL_OFFSET, 32'h8);
    repeat (2) @(posedge clk);
    chk({lock_one, lane_locked}, 32'h0);
    wait_up();
    chk({wide_mode, lanes_aligned, odd_pair_tx_enable}, 32'h7);
    link_partner_model_i.send_error(3);
    groups(2);
    link_partner_model_i.send_error(3);
    groups(5);
    chk({lanes_aligned, link_up, idle_only}, 32'h1);
    apb(1'b1, lane_sync_pkg::CTRL_OFFSET, 32'h9);
    wait_up();
    chk({wide_mode, alt_lane_selected}, 32'h0);
    // With the pins quiet only the bypass bit lets the lanes lock again
    energy_ok <= 4'h0;
    apb(1'b1, lane_sync_pkg::CTRL_OFFSET, 32'hF);
    repeat (2950) @(posedge clk);
    chk({29'h0, even_pair_tx_enable, tx_dual, tx_one}, 32'h0);
    repeat (100) @(posedge clk);
    chk({29'h0, even_pair_tx_enable, tx_dual, tx_one}, 32'h5);
    repeat (150) @(posedge clk);
    chk({link_up, odd_pair_tx_enable}, 32'h1);
    wait_up();
    st(32'h0E0, 32'h0A0);
    complete_run();
  end
endmodule : tb_serial_lane_sync_monitor
